// [hw/dgd_gate_drive_ctrl.sv]
// Dual gate drive control with lockouts, fault pin hold-off and AXI4-Lite
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module dgd_gate_drive_ctrl #(
  parameter int unsigned HOLD_CYCLES = dgd_pkg::HOLD_CYC
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                chan_a_input,
  input  wire logic                chan_b_input,
  input  wire dgd_pkg::dgd_faults_s lock_flags,
  output logic                     chan_a_gate_out,
  output logic                     chan_b_gate_out,
  input  wire logic                fault_out_n_i,
  output logic                     fault_out_n_o,
  output logic                     fault_out_n_oe_n,
  output logic                     irq,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp
);
  import dgd_pkg::*;

  localparam int unsigned CNT_W = $clog2(HOLD_CYCLES + 1);
  localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYCLES);

  // Refused at elaboration: a zero hold-off would let the pin chatter
  if (HOLD_CYCLES < 1 || CNT_W > 32) begin : gen_hold_check
    $error("HOLD_CYCLES must be between 1 and 2**32-1");
  end

  // Pin synchronisers; the first stage feeds the second only
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      // Samples start low, as an undriven logic input would through its pull-down, the pulled-up fault pin included
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {fault_out_n_i, chan_b_input, chan_a_input};
      sync2_q <= sync1_q;
    end
  end

  wire in_a_s  = sync2_q[0];
  wire in_b_s  = sync2_q[1];
  wire pin_s   = sync2_q[2];

  // Gate decisions
  logic [1:0] ctrl_q;
  wire lock_all  = lock_flags.over_temp | lock_flags.supply_uv
                 | lock_flags.supply_ov;
  wire gate_a_d  = in_a_s & ctrl_q[CTRL_EN_A] & ~lock_all
                 & ~lock_flags.float_a_uv;
  wire gate_b_d  = in_b_s & ctrl_q[CTRL_EN_B] & ~lock_all
                 & ~lock_flags.float_b_uv;
  wire any_fault = |lock_flags;

  // Fault hold-off counter, reloaded while any fault stands
  logic [CNT_W-1:0] hold_cnt_q;
  wire  [CNT_W-1:0] hold_cnt_d = any_fault ? HOLD_LOAD :
                                 (hold_cnt_q != '0) ? hold_cnt_q - 1'b1 :
                                 hold_cnt_q;
  wire pin_low_d = any_fault | (hold_cnt_q != '0);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      chan_a_gate_out  <= 1'b0;
      chan_b_gate_out  <= 1'b0;
      hold_cnt_q       <= '0;
      fault_out_n_oe_n <= 1'b1;
    end else begin
      chan_a_gate_out  <= gate_a_d;
      chan_b_gate_out  <= gate_b_d;
      hold_cnt_q       <= hold_cnt_d;
      fault_out_n_oe_n <= ~pin_low_d;
    end
  end

  // Open drain: only ever pulls low, the board pulls it high
  always_ff @(posedge core_clk) begin
    fault_out_n_o <= 1'b0;
  end

  // Interrupt events: each flag rising, and the fault pin releasing
  dgd_faults_s flags_prev_q;
  logic        pin_low_prev_q;
  logic [NUM_EVT-1:0] int_stat_q;
  logic [NUM_EVT-1:0] int_mask_q;

  wire [4:0] flag_rise = lock_flags & ~flags_prev_q;
  wire       released  = pin_low_prev_q & fault_out_n_oe_n;
  wire [NUM_EVT-1:0] evt = {released, flag_rise};

  // AXI4-Lite write path: address and data taken in either order
  logic       aw_full_q;
  logic       w_full_q;
  logic [7:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic       wstrb0_q;

  wire aw_hs    = s_axi_awvalid & s_axi_awready;
  wire w_hs     = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire aw_full_d = (aw_full_q | aw_hs) & ~do_write;
  wire w_full_d  = (w_full_q | w_hs) & ~do_write;
  wire bvalid_d  = do_write | (s_axi_bvalid & ~s_axi_bready);

  wire wr_ctrl = do_write & wstrb0_q & (awaddr_q == OFS_CTRL);
  wire wr_stat = do_write & wstrb0_q & (awaddr_q == OFS_INT_STAT);
  wire wr_mask = do_write & wstrb0_q & (awaddr_q == OFS_INT_MASK);
  wire wr_hit  = (awaddr_q == OFS_CTRL) | (awaddr_q == OFS_STATUS)
               | (awaddr_q == OFS_INT_STAT) | (awaddr_q == OFS_INT_MASK)
               | (awaddr_q == OFS_HOLD);

  wire [NUM_EVT-1:0] clr_bits   = wr_stat ? wbyte_q[NUM_EVT-1:0] : '0;
  // A new event in the clearing cycle survives the clear
  wire [NUM_EVT-1:0] int_stat_d = (int_stat_q & ~clr_bits) | evt;
  // irq uses the next mask so it never lags a mask write by a cycle
  wire [NUM_EVT-1:0] int_mask_d = wr_mask ? wbyte_q[NUM_EVT-1:0]
                                          : int_mask_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aw_full_q      <= 1'b0;
      w_full_q       <= 1'b0;
      awaddr_q       <= 8'h00;
      wbyte_q        <= 8'h00;
      wstrb0_q       <= 1'b0;
      s_axi_awready  <= 1'b0;
      s_axi_wready   <= 1'b0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= RESP_OKAY;
    end else begin
      aw_full_q      <= aw_full_d;
      w_full_q       <= w_full_d;
      s_axi_awready  <= ~aw_full_d & ~bvalid_d;
      s_axi_wready   <= ~w_full_d & ~bvalid_d;
      s_axi_bvalid   <= bvalid_d;
      if (aw_hs) begin
        awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (w_hs) begin
        wbyte_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_q         <= CTRL_RST;
      int_mask_q     <= INT_MASK_RST;
      int_stat_q     <= '0;
      flags_prev_q   <= '0;
      pin_low_prev_q <= 1'b0;
      irq            <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wbyte_q[1:0];
      end
      int_mask_q     <= int_mask_d;
      int_stat_q     <= int_stat_d;
      flags_prev_q   <= lock_flags;
      pin_low_prev_q <= ~fault_out_n_oe_n;
      irq            <= |(int_stat_d & int_mask_d);
    end
  end

  // AXI4-Lite read path: one read outstanding, answer one cycle after
  wire ar_hs    = s_axi_arvalid & s_axi_arready;
  wire rvalid_d = ar_hs | (s_axi_rvalid & ~s_axi_rready);
  wire [7:0] raddr = {s_axi_araddr[7:2], 2'h0};

  logic [31:0] status_w;
  assign status_w = {23'h0, pin_s, chan_b_gate_out, chan_a_gate_out,
                     ~fault_out_n_oe_n, lock_flags};

  wire rd_ctrl = (raddr == OFS_CTRL);
  wire rd_st   = (raddr == OFS_STATUS);
  wire rd_is   = (raddr == OFS_INT_STAT);
  wire rd_im   = (raddr == OFS_INT_MASK);
  wire rd_hold = (raddr == OFS_HOLD);
  wire rd_hit  = rd_ctrl | rd_st | rd_is | rd_im | rd_hold;

  wire [31:0] rd_mux =
      rd_ctrl ? {30'h0, ctrl_q} :
      rd_st   ? status_w :
      rd_is   ? {26'h0, int_stat_q} :
      rd_im   ? {26'h0, int_mask_q} :
      rd_hold ? 32'(hold_cnt_q) : 32'h0;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid  <= rvalid_d;
      if (ar_hs) begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence fault_gone_s;
    any_fault ##1 !any_fault;
  endsequence

  gate_a_follow_a: assert property (
    gate_a_d |=> chan_a_gate_out)
    else $error("channel A gate did not follow its input");

  gate_b_follow_a: assert property (
    (in_b_s && ctrl_q[1] && !lock_all && !lock_flags.float_b_uv)
    |=> chan_b_gate_out)
    else $error("channel B gate did not follow its input");

  input_low_a: assert property (
    (!in_a_s || !in_b_s) |=>
      ($past(in_a_s) || !chan_a_gate_out) &&
      ($past(in_b_s) || !chan_b_gate_out))
    else $error("gate high while its input was low");

  thermal_off_a: assert property (
    lock_flags.over_temp |=> !chan_a_gate_out && !chan_b_gate_out)
    else $error("gate high during overtemperature");

  supply_lock_a: assert property (
    (lock_flags.supply_uv || lock_flags.supply_ov)
    |=> !chan_a_gate_out && !chan_b_gate_out)
    else $error("gate high during supply lockout");

  float_uv_a: assert property (
    lock_flags.float_a_uv |=> !chan_a_gate_out)
    else $error("channel A gate high during its supply lockout");

  chan_isolate_a: assert property (
    (lock_flags.float_a_uv && !lock_flags.float_b_uv && !lock_all &&
     in_b_s && ctrl_q[1]) |=> chan_b_gate_out)
    else $error("channel B held by channel A supply lockout");

  fault_now_a: assert property (
    any_fault |=> !fault_out_n_oe_n && !fault_out_n_o)
    else $error("fault pin not pulled low at once");

  holdoff_load_a: assert property (
    fault_gone_s |-> hold_cnt_q == HOLD_LOAD ##1 !fault_out_n_oe_n)
    else $error("hold-off not started when faults cleared");

  release_gate_a: assert property (
    $rose(fault_out_n_oe_n) |->
      $past(hold_cnt_q) == '0 && !$past(any_fault))
    else $error("fault pin released before hold-off ended");

  irq_level_a: assert property (
    irq == |(int_stat_q & int_mask_q))
    else $error("interrupt level differs from unmasked status");

  // Hold-off countdown: no fault stands and time is still left
  sequence counting_s;
    !any_fault && hold_cnt_q != '0;
  endsequence

  float_uv_b_a: assert property (
    lock_flags.float_b_uv |=> !chan_b_gate_out)
    else $error("channel B gate high during its supply lockout");

  chan_isolate_b_a: assert property (
    (lock_flags.float_b_uv && !lock_flags.float_a_uv && !lock_all &&
     in_a_s && ctrl_q[CTRL_EN_A]) |=> chan_a_gate_out)
    else $error("channel A held by channel B supply lockout");

  gate_enable_a: assert property (
    !ctrl_q[CTRL_EN_A] |=> !chan_a_gate_out)
    else $error("channel A gate high while disabled");

  gate_enable_b_a: assert property (
    !ctrl_q[CTRL_EN_B] |=> !chan_b_gate_out)
    else $error("channel B gate high while disabled");

  open_drain_a: assert property (
    !fault_out_n_o)
    else $error("fault pin driven high");

  pin_release_a: assert property (
    (!any_fault && hold_cnt_q == '0) |=> fault_out_n_oe_n)
    else $error("fault pin held low with no fault and no hold-off");

  holdoff_reload_a: assert property (
    any_fault |=> hold_cnt_q == HOLD_LOAD)
    else $error("hold-off not reloaded by a standing fault");

  holdoff_step_a: assert property (
    counting_s |=> hold_cnt_q == $past(hold_cnt_q) - 1'b1)
    else $error("hold-off did not count down by one");

  pin_held_a: assert property (
    counting_s |=> !fault_out_n_oe_n)
    else $error("fault pin released during hold-off");

  event_set_a: assert property (
    (|evt) |=> (int_stat_q & $past(evt)) == $past(evt))
    else $error("interrupt event lost");

  // A response must stand unchanged until the master takes it
  bresp_hold_a: assert property (
    (s_axi_bvalid && !s_axi_bready) |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");

  rdata_hold_a: assert property (
    (s_axi_rvalid && !s_axi_rready) |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response changed before it was taken");

endmodule // dgd_gate_drive_ctrl

`default_nettype wire

// [hw/dgd_pkg.sv]
// Constants and types for the dual gate drive fault logic
//
// How it works
// - Each gate follows its own logic input, independent of the other.
// - An undriven logic input counts as low, so its gate stays low.
// - Overtemperature forces both gates low until its flag clears.
// - Main supply lockout (under or over voltage) holds both gates low.
// - A floating supply undervoltage holds only its own gate low.
// - One floating lockout leaves the other channel free; global ones win.
// - The active-low fault pin is pulled low at once while any fault stands.
// - Pin stays low a fixed hold-off after faults clear; a fault restarts it.
package dgd_pkg;

  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned HOLD_US      = 100;
  localparam int unsigned HOLD_CYC     = HOLD_US * CLK_MHZ;

  localparam int unsigned AXI_AW       = 8;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_STATUS   = 8'h04;
  localparam logic [7:0]  OFS_INT_STAT = 8'h08;
  localparam logic [7:0]  OFS_INT_MASK = 8'h0C;
  localparam logic [7:0]  OFS_HOLD     = 8'h10;

  localparam int unsigned CTRL_EN_A    = 0;
  localparam int unsigned CTRL_EN_B    = 1;
  localparam logic [1:0]  CTRL_RST     = 2'h3;

  localparam int unsigned ST_FAULT_LO  = 0;
  localparam int unsigned ST_PIN_LOW   = 5;
  localparam int unsigned ST_GATE_A    = 6;
  localparam int unsigned ST_GATE_B    = 7;
  localparam int unsigned ST_PIN_SENSE = 8;

  localparam int unsigned NUM_EVT      = 6;
  localparam int unsigned EVT_RELEASE  = 5;
  localparam logic [5:0]  INT_MASK_RST = 6'h00;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Lockout and temperature flags, one bit each
  typedef struct packed {
    logic float_b_uv;
    logic float_a_uv;
    logic supply_ov;
    logic supply_uv;
    logic over_temp;
  } dgd_faults_s;

endpackage

// [verification/dgd_ctrl_model.sv]
// Regulator controller model driving the two logic inputs
`timescale 1ns/1ps
`default_nettype none

module dgd_ctrl_model (
  input  wire logic core_clk,
  input  wire logic want_a,
  input  wire logic want_b,
  input  wire logic float_in,
  input  wire logic flt_o,
  input  wire logic flt_oe_n,
  output var logic  chan_a_input = 1'b0,
  output var logic  chan_b_input = 1'b0,
  output logic      flt_wire
);
  // A released input rests low through the pull-down
  always @(posedge core_clk) begin
    chan_a_input <= want_a & ~float_in;
    chan_b_input <= want_b & ~float_in;
  end
  // Board pull-up; the device only ever sinks the wire
  assign flt_wire = flt_oe_n ? 1'b1 : flt_o;
endmodule // dgd_ctrl_model

`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the dual gate drive control block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import dgd_pkg::*;
  localparam int HOLD = 8;
  logic core_clk = 0, rst_n = 0, want_a = 0, want_b = 0, flt_in = 0;
  logic chan_a_input, chan_b_input, chan_a_gate_out, chan_b_gate_out;
  logic fault_out_n_o, fault_out_n_oe_n, flt_wire, irq;
  dgd_faults_s lock_flags = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  int n_fail = 0, checks_done = 0;

  always #5 core_clk = ~core_clk;

  dgd_ctrl_model ctl (.core_clk, .want_a, .want_b, .float_in(flt_in),
    .flt_o(fault_out_n_o), .flt_oe_n(fault_out_n_oe_n),
    .chan_a_input, .chan_b_input, .flt_wire);

  dgd_gate_drive_ctrl #(.HOLD_CYCLES(HOLD)) uut (.core_clk, .rst_n,
    .chan_a_input, .chan_b_input, .lock_flags, .chan_a_gate_out,
    .chan_b_gate_out, .fault_out_n_i(flt_wire), .fault_out_n_o,
    .fault_out_n_oe_n, .irq, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp);

  task results;
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bit b;
    @(posedge core_clk);
    b = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (int n = 0; n < 50 && !b; n++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin
        b = 1;
        wr_r = s_axi_bresp;
        s_axi_bready <= 0;
      end
    end
    if (!b) begin
      n_fail++;
      results();
    end
  endtask

  task rd(input logic [7:0] a);
    bit b;
    @(posedge core_clk);
    b = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int n = 0; n < 50 && !b; n++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin
        b = 1;
        rd_v = s_axi_rdata;
        rd_r = s_axi_rresp;
        s_axi_rready <= 0;
      end
    end
    if (!b) begin
      n_fail++;
      results();
    end
  endtask

  task settle(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask

  // Fault wire must still be low HOLD cycles after the faults clear, then release one cycle later
  task hold_chk;
    @(posedge core_clk);
    lock_flags <= '0;
    settle(HOLD);
    cmp(flt_wire, 0);
    settle(1);
    cmp(flt_wire, 1);
  endtask

  initial begin
    settle(6);
    rst_n <= 1;
    settle(3);
    cmp({chan_a_gate_out, chan_b_gate_out, flt_wire}, 3'h1);
    rd(OFS_CTRL);
    cmp(rd_v, 32'h3);
    rd(OFS_INT_MASK);
    cmp(rd_v, 32'h0);
    rd(OFS_HOLD);
    cmp(rd_v, 32'h0);
    // Every input pairing, overlap included
    for (int k = 0; k < 4; k++) begin
      want_a <= k[0];
      want_b <= k[1];
      settle(6);
      cmp({chan_a_gate_out, chan_b_gate_out}, {k[0], k[1]});
    end
    rd(OFS_STATUS);
    cmp(rd_v, 32'h1C0);
    flt_in <= 1;
    settle(6);
    cmp({chan_a_gate_out, chan_b_gate_out}, 2'h0);
    flt_in <= 0;
    // Each flag alone with both inputs high
    for (int i = 0; i < 5; i++) begin
      lock_flags <= 5'h01 << i;
      settle(3);
      cmp({chan_a_gate_out, chan_b_gate_out},
          (i == 3) ? 2'h1 : (i == 4) ? 2'h2 : 2'h0);
      cmp(flt_wire, 0);
      cmp(fault_out_n_o, 0);
      hold_chk();
    end
    cmp(irq, 0);
    rd(OFS_INT_STAT);
    cmp(rd_v, 32'h3F);
    wr(OFS_INT_MASK, 32'h20);
    settle(2);
    cmp(irq, 1);
    wr(OFS_INT_STAT, 32'h3F);
    settle(2);
    cmp(irq, 0);
    rd(OFS_INT_STAT);
    cmp(rd_v, 32'h0);
    // A new fault part way through restarts the hold-off
    lock_flags <= 5'h02;
    settle(2);
    lock_flags <= '0;
    settle(4);
    lock_flags <= 5'h02;
    hold_chk();
    wr(OFS_CTRL, 32'h0);
    settle(2);
    cmp({chan_a_gate_out, chan_b_gate_out}, 2'h0);
    wr(OFS_CTRL, 32'h3);
    cmp(wr_r, RESP_OKAY);
    settle(2);
    cmp({chan_a_gate_out, chan_b_gate_out}, 2'h3);
    wr(8'h20, 32'h0);
    cmp(wr_r, RESP_SLVERR);
    rd(8'h20);
    cmp(rd_v, 32'h0);
    cmp(rd_r, RESP_SLVERR);
    results();
  end
endmodule // testbench

`default_nettype wire
